// ---- rrsf_defs.svh ----
// Constants for the rotate-right and set-file execution block.
// Assumes inclusion by bare name from files in the same folder.
// What this block does
// - Rotate through carry shifts the operand right, old bit 0 goes to carry, old carry to bit 7.
// - Rotate through carry is coded with top byte 0011 00da and an eight-bit file address.
// - Rotate through carry updates the carry, negative and zero flags from its result.
// - Plain rotate shifts the operand right, old bit 0 goes to bit 7, carry is untouched.
// - Plain rotate is coded with top byte 0100 00da and an eight-bit file address.
// - Plain rotate updates only the negative and zero flags.
// - Destination bit 0 sends the rotate result to the working register, 1 to the file register.
// - Bank-access bit 0 selects the access bank and ignores the bank select register.
// - Bank-access bit 1 takes the data memory bank from the bank select register.
// - Access bank with extended set enabled and address at most 95 uses indexed literal offset.
// - Fill-ones writes FFh into the addressed file register.
// - Fill-ones is coded with top byte 0110 100a and an eight-bit file address.
// - Fill-ones leaves every status flag unchanged.
// - Each instruction is one program word and completes in one instruction cycle.
// - Phase one decodes, phase two requests the file read, phase three reads the file, phase four processes and writes.
`ifndef RRSF_DEFS_SVH
`define RRSF_DEFS_SVH
`define RRSF_OPC_RRC_MASK 8'hfc
`define RRSF_OPC_RRC_VAL 8'h30
`define RRSF_OPC_RRN_MASK 8'hfc
`define RRSF_OPC_RRN_VAL 8'h40
`define RRSF_OPC_SET_MASK 8'hfe
`define RRSF_OPC_SET_VAL 8'h68
`define RRSF_D_BIT 9
`define RRSF_A_BIT 8
`define RRSF_IDX_LIMIT 8'h5f
`define RRSF_ACC_SPLIT 8'h60
`define RRSF_ACC_HI_BANK 4'hf
`define RRSF_FILL_VAL 8'hff
`define RRSF_RST_W 8'h00
`define RRSF_RST_STAT 3'h0
`endif

// ---- rrsf_exec.sv ----
// Execution of rotate-through-carry, plain rotate and fill-ones instructions.
// Assumes the fetch unit presents a word each Q1 and data memory answers within the strobe cycle.
`timescale 1ns/1ps
`default_nettype none
`include "rrsf_defs.svh"
module rrsf_exec (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Instruction from fetch
  input wire logic [15:0] instr_i,
  input wire logic instr_valid_i,
  // Configuration
  input wire logic ext_set_en_i,
  input wire logic [3:0] bank_select_reg_i,
  input wire logic [7:0] fsr2_base_i,
  // Data memory
  output rrsf_pkg::rrsf_mem_s mem_rd_o,
  output logic mem_rd_en_o,
  input wire logic [7:0] mem_rd_data_i,
  output rrsf_pkg::rrsf_mem_s mem_wr_o,
  output logic mem_wr_en_o,
  // Core state
  output logic [7:0] w_o,
  output rrsf_pkg::rrsf_flags_s flags_o,
  output logic [1:0] phase_o,
  output logic instr_done_o,
  output logic instr_hit_o
);
  rrsf_pkg::rrsf_phase_e phase_reg;
  rrsf_pkg::rrsf_op_e op_reg;
  rrsf_pkg::rrsf_op_e op_next;
  logic dest_file_reg;
  logic [11:0] addr_reg;
  logic [11:0] addr_next;
  logic [7:0] operand_reg;
  logic [7:0] result_c;
  rrsf_pkg::rrsf_flags_s flags_reg;
  rrsf_pkg::rrsf_flags_s flags_c;
  logic [7:0] w_reg;
  rrsf_pkg::rrsf_mem_s mem_rd_reg;
  logic mem_rd_en_reg;
  rrsf_pkg::rrsf_mem_s mem_wr_reg;
  logic mem_wr_en_reg;
  logic done_reg;

  // Opcode decode, used for the operation and the hit flag
  function automatic rrsf_pkg::rrsf_op_e rrsf_decode(input logic [15:0] iw);
    if ((iw[15:8] & `RRSF_OPC_RRC_MASK) == `RRSF_OPC_RRC_VAL) begin
      rrsf_decode = rrsf_pkg::RRSF_OP_RRC;
    end else if ((iw[15:8] & `RRSF_OPC_RRN_MASK) == `RRSF_OPC_RRN_VAL) begin
      rrsf_decode = rrsf_pkg::RRSF_OP_RRN;
    end else if ((iw[15:8] & `RRSF_OPC_SET_MASK) == `RRSF_OPC_SET_VAL) begin
      rrsf_decode = rrsf_pkg::RRSF_OP_SET;
    end else begin
      rrsf_decode = rrsf_pkg::RRSF_OP_NONE;
    end
  endfunction : rrsf_decode

  // Effective address formation from the a bit and file field
  function automatic logic [11:0] rrsf_ea(input logic [15:0] iw, input logic ext,
                                          input logic [3:0] bank, input logic [7:0] base);
    logic [7:0] f;
    f = iw[7:0];
    if (iw[`RRSF_A_BIT]) begin
      rrsf_ea = {bank, f};
    end else if (ext && (f <= `RRSF_IDX_LIMIT)) begin
      rrsf_ea = {4'h0, 8'(base + f)};
    end else if (f < `RRSF_ACC_SPLIT) begin
      rrsf_ea = {4'h0, f};
    end else begin
      rrsf_ea = {`RRSF_ACC_HI_BANK, f};
    end
  endfunction : rrsf_ea

  assign op_next = rrsf_decode(instr_i);
  assign addr_next = rrsf_ea(instr_i, ext_set_en_i, bank_select_reg_i, fsr2_base_i);

  rrsf_flag_unit u_flag (
    .op_i(op_reg),
    .operand_i(operand_reg),
    .flags_i(flags_reg),
    .result_o(result_c),
    .flags_o(flags_c)
  );

  // Four-phase sequencer, one instruction cycle per word
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      phase_reg <= rrsf_pkg::RRSF_PH_Q1;
    end else begin
      case (phase_reg)
        rrsf_pkg::RRSF_PH_Q1: phase_reg <= rrsf_pkg::RRSF_PH_Q2;
        rrsf_pkg::RRSF_PH_Q2: phase_reg <= rrsf_pkg::RRSF_PH_Q3;
        rrsf_pkg::RRSF_PH_Q3: phase_reg <= rrsf_pkg::RRSF_PH_Q4;
        rrsf_pkg::RRSF_PH_Q4: phase_reg <= rrsf_pkg::RRSF_PH_Q1;
        default: phase_reg <= rrsf_pkg::RRSF_PH_Q1;
      endcase
    end
  end

  // Q1 decode of operation, destination and address
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      op_reg <= rrsf_pkg::RRSF_OP_NONE;
      dest_file_reg <= 1'b1;
      addr_reg <= 12'h000;
    end else if (phase_reg == rrsf_pkg::RRSF_PH_Q1) begin
      op_reg <= instr_valid_i ? op_next : rrsf_pkg::RRSF_OP_NONE;
      dest_file_reg <= (op_next == rrsf_pkg::RRSF_OP_SET) || instr_i[`RRSF_D_BIT];
      addr_reg <= addr_next;
    end
  end

  // Q2 file read request; the strobe stands in Q3 and data is taken at its end
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      mem_rd_reg <= '0;
      mem_rd_en_reg <= 1'b0;
    end else begin
      mem_rd_en_reg <= (phase_reg == rrsf_pkg::RRSF_PH_Q2) &&
                       (op_reg != rrsf_pkg::RRSF_OP_NONE);
      mem_rd_reg.addr <= addr_reg;
      mem_rd_reg.data <= 8'h00;
    end
  end

  // Q3 operand capture; the flag unit processes it during Q4
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      operand_reg <= 8'h00;
    end else if (phase_reg == rrsf_pkg::RRSF_PH_Q3) begin
      operand_reg <= mem_rd_data_i;
    end
  end

  // Q4 write of destination, status and working register
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      w_reg <= `RRSF_RST_W;
      flags_reg <= `RRSF_RST_STAT;
      mem_wr_reg <= '0;
      mem_wr_en_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      mem_wr_en_reg <= 1'b0;
      done_reg <= 1'b0;
      if (phase_reg == rrsf_pkg::RRSF_PH_Q4 && op_reg != rrsf_pkg::RRSF_OP_NONE) begin
        done_reg <= 1'b1;
        flags_reg <= flags_c;
        if (dest_file_reg) begin
          mem_wr_en_reg <= 1'b1;
          mem_wr_reg.addr <= addr_reg;
          mem_wr_reg.data <= result_c;
        end else begin
          w_reg <= result_c;
        end
      end
    end
  end

  assign mem_rd_o = mem_rd_reg;
  assign mem_rd_en_o = mem_rd_en_reg;
  assign mem_wr_o = mem_wr_reg;
  assign mem_wr_en_o = mem_wr_en_reg;
  assign w_o = w_reg;
  assign flags_o = flags_reg;
  assign phase_o = phase_reg;
  assign instr_done_o = done_reg;
  assign instr_hit_o = (op_next != rrsf_pkg::RRSF_OP_NONE);
endmodule : rrsf_exec
`default_nettype wire

// ---- rrsf_exec_bench.sv ----
// Self-checking bench for the rotate and fill-ones execution block.
// Assumes the block, its checker and the memory model in this folder.
`timescale 1ns/1ps
`default_nettype none
module rrsf_exec_bench;
  typedef struct packed {
    logic [15:0] ins;
    logic [3:0] bank;
    logic ext;
    logic [7:0] opnd;
    logic [11:0] addr;
    logic [7:0] res;
    logic [2:0] fl;
    logic wr;
  } rrsf_row_s;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [15:0] instr_i = 16'h0000;
  logic instr_valid_i = 1'b0;
  logic ext_set_en_i = 1'b0;
  logic [3:0] bank_select_reg_i = 4'h0;
  logic [7:0] mem_rd_data_i;
  rrsf_pkg::rrsf_mem_s mem_rd_o;
  rrsf_pkg::rrsf_mem_s mem_wr_o;
  logic mem_rd_en_o;
  logic mem_wr_en_o;
  logic [7:0] w_o;
  logic [7:0] w_now = 8'h00;
  rrsf_pkg::rrsf_flags_s flags_o;
  logic [1:0] phase_o;
  logic instr_done_o;
  logic instr_hit_o;
  int num_errors = 0;
  int check_count = 0;
  // Word, bank, extended set, operand, address, result, flags, file write
  rrsf_row_s rows [7] = '{
    '{16'h3210, 4'h9, 1'b0, 8'h01, 12'h010, 8'h00, 3'h5, 1'b1},
    '{16'h3122, 4'h3, 1'b0, 8'he6, 12'h322, 8'hf3, 3'h2, 1'b0},
    '{16'h4280, 4'h5, 1'b0, 8'hd7, 12'hf80, 8'heb, 3'h2, 1'b1},
    '{16'h4005, 4'h0, 1'b1, 8'h01, 12'h045, 8'h80, 3'h2, 1'b0},
    '{16'h6933, 4'h7, 1'b0, 8'h00, 12'h733, 8'hff, 3'h2, 1'b1},
    '{16'h685f, 4'h0, 1'b1, 8'h00, 12'h09f, 8'hff, 3'h2, 1'b1},
    '{16'h3260, 4'h0, 1'b1, 8'h80, 12'hf60, 8'h40, 3'h0, 1'b1}};
  // Clock
  always #4 sys_clk_i = ~sys_clk_i;
  rrsf_exec i_rrsf_exec (.sys_clk_i, .srst_i, .instr_i, .instr_valid_i, .ext_set_en_i,
    .bank_select_reg_i, .fsr2_base_i(8'h40), .mem_rd_o, .mem_rd_en_o, .mem_rd_data_i,
    .mem_wr_o, .mem_wr_en_o, .w_o, .flags_o, .phase_o, .instr_done_o, .instr_hit_o);
  rrsf_mem_model i_rrsf_mem_model (.sys_clk_i, .rd_i(mem_rd_o), .rd_en_i(mem_rd_en_o),
    .wr_i(mem_wr_o), .wr_en_i(mem_wr_en_o), .rd_data_o(mem_rd_data_i));
  task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  // Bounded wait for the decode phase
  task automatic to_q1();
    int n;
    n = 0;
    while (phase_o !== 2'h0 && n < 8) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (n == 8) begin
      num_errors++;
      wrap_up();
    end
  endtask : to_q1
  // One instruction, bank disturbed after decode
  task automatic run(input rrsf_row_s r);
    to_q1();
    i_rrsf_mem_model.mem[r.addr] = r.opnd;
    instr_i = r.ins;
    instr_valid_i = 1'b1;
    bank_select_reg_i = r.bank;
    ext_set_en_i = r.ext;
    @(posedge sys_clk_i);
    #1;
    chk("hit", 20'h1, {19'h0, instr_hit_o});
    instr_valid_i = 1'b0;
    bank_select_reg_i = ~r.bank;
    @(posedge sys_clk_i);
    #1;
    chk("read addr", {8'h1, r.addr}, {7'h0, mem_rd_en_o, mem_rd_o.addr});
    repeat (2) @(posedge sys_clk_i);
    #1;
    if (!r.wr) w_now = r.res;
    chk("done", 20'h1, {19'h0, instr_done_o});
    chk("write strobe", {19'h0, r.wr}, {19'h0, mem_wr_en_o});
    if (r.wr) chk("write", {r.addr, r.res}, mem_wr_o);
    chk("w", {12'h0, w_now}, {12'h0, w_o});
    chk("flags", {17'h0, r.fl}, {17'h0, flags_o});
  endtask : run
  initial begin
    repeat (2) @(posedge sys_clk_i);
    #1;
    srst_i = 1'b0;
    chk("reset", 20'h0, {7'h0, phase_o, flags_o, w_o});
    foreach (rows[i]) run(rows[i]);
    $display("row tests done");
    // Foreign opcode is refused
    to_q1();
    instr_i = 16'h3600;
    instr_valid_i = 1'b1;
    #1;
    chk("hit", 20'h0, {19'h0, instr_hit_o});
    repeat (5) @(posedge sys_clk_i);
    #1;
    chk("refused", 20'h0, {16'h0, instr_done_o, flags_o});
    $display("refusal test done");
    // Reset in the middle of an instruction
    to_q1();
    instr_i = 16'h3010;
    repeat (2) @(posedge sys_clk_i);
    #1;
    instr_valid_i = 1'b0;
    srst_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    srst_i = 1'b0;
    chk("mid reset", 20'h0, {6'h0, phase_o, instr_done_o, flags_o, w_o});
    // First word right after the release runs in full
    w_now = 8'h00;
    run(rows[0]);
    $display("reset test done");
    wrap_up();
  end
endmodule : rrsf_exec_bench
`default_nettype wire

// ---- rrsf_exec_props.sv ----
// Checker for the rotate and fill-ones execution block.
// Assumes binding to rrsf_exec, seeing its ports only.
`timescale 1ns/1ps
`default_nettype none
module rrsf_exec_props (
  // Watched ports
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [15:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic mem_rd_en_o,
  input wire rrsf_pkg::rrsf_mem_s mem_wr_o,
  input wire logic mem_wr_en_o,
  input wire rrsf_pkg::rrsf_flags_s flags_o,
  input wire logic [1:0] phase_o,
  input wire logic instr_done_o,
  input wire logic instr_hit_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // Accepted word and whether it rotates
  logic tk;
  logic rot;
  assign tk = phase_o == 2'h0 && instr_valid_i && instr_hit_o;
  assign rot = instr_i[15:10] == 6'h0c || instr_i[15:10] == 6'h10;
  a_phase_step: assert property (1 |=> phase_o == $past(phase_o) + 2'h1)
    else $error("phase skipped");
  a_read_strobe: assert property (tk |-> ##2 mem_rd_en_o && phase_o == 2'h2)
    else $error("read strobe misplaced");
  a_one_cycle: assert property (tk |-> ##4 instr_done_o && phase_o == 2'h0)
    else $error("not done in one cycle");
  a_no_stray: assert property (phase_o == 2'h0 && !tk |-> ##4 !instr_done_o)
    else $error("stray completion");
  a_rot_dest: assert property (tk && rot |-> ##4 mem_wr_en_o == $past(instr_i[9], 4))
    else $error("wrong destination");
  a_fill_value: assert property (tk && !rot |-> ##4 mem_wr_en_o && mem_wr_o.data == 8'hff)
    else $error("fill value wrong");
  a_fill_flags: assert property (tk && !rot |-> ##4 $stable(flags_o))
    else $error("fill changed flags");
  a_plain_carry: assert property (tk && instr_i[15:10] == 6'h10 |-> ##4 $stable(flags_o.carry))
    else $error("plain rotate changed carry");
  a_nz_flags: assert property (tk && rot && instr_i[9] |-> ##4 flags_o.zero ==
    (mem_wr_o.data == 8'h00) && flags_o.neg == mem_wr_o.data[7]) else $error("bad n or z");
  // Main cases reached
  c_rot_w: cover property (tk && rot && !instr_i[9]);
  c_rot_f: cover property (tk && rot && instr_i[9]);
  c_fill: cover property (tk && !rot);
endmodule : rrsf_exec_props
bind rrsf_exec rrsf_exec_props i_props (.sys_clk_i, .srst_i, .instr_i, .instr_valid_i,
  .mem_rd_en_o, .mem_wr_o, .mem_wr_en_o, .flags_o, .phase_o, .instr_done_o, .instr_hit_o);
`default_nettype wire

// ---- rrsf_flag_unit.sv ----
// Result and flag calculation for the three instructions.
// Assumes a decoded operation and operand held stable for the cycle.
`timescale 1ns/1ps
`default_nettype none
`include "rrsf_defs.svh"
module rrsf_flag_unit (
  // Operation and operand
  input wire rrsf_pkg::rrsf_op_e op_i,
  input wire logic [7:0] operand_i,
  input wire rrsf_pkg::rrsf_flags_s flags_i,
  // Result
  output logic [7:0] result_o,
  output rrsf_pkg::rrsf_flags_s flags_o
);
  // Datapath and flag update
  always_comb begin
    result_o = operand_i;
    flags_o = flags_i;
    case (op_i)
      rrsf_pkg::RRSF_OP_RRC: begin
        result_o = {flags_i.carry, operand_i[7:1]};
        flags_o.carry = operand_i[0];
        flags_o.neg = flags_i.carry;
        flags_o.zero = ({flags_i.carry, operand_i[7:1]} == 8'h00);
      end
      rrsf_pkg::RRSF_OP_RRN: begin
        result_o = {operand_i[0], operand_i[7:1]};
        flags_o.neg = operand_i[0];
        flags_o.zero = (operand_i == 8'h00);
      end
      rrsf_pkg::RRSF_OP_SET: begin
        result_o = `RRSF_FILL_VAL;
      end
      default: begin
        result_o = operand_i;
      end
    endcase
  end
endmodule : rrsf_flag_unit
`default_nettype wire

// ---- rrsf_mem_model.sv ----
// Data memory model facing the execution block.
// Assumes the bench preloads the locations it reads.
`timescale 1ns/1ps
`default_nettype none
module rrsf_mem_model (
  // Clock
  input wire logic sys_clk_i,
  // Requests from the block
  input wire rrsf_pkg::rrsf_mem_s rd_i,
  input wire logic rd_en_i,
  input wire rrsf_pkg::rrsf_mem_s wr_i,
  input wire logic wr_en_i,
  // Read data
  output logic [7:0] rd_data_o
);
  logic [7:0] mem [4096];
  logic [7:0] noise_reg = 8'h00;
  // Data shown only while the strobe stands, toggling otherwise
  assign rd_data_o = rd_en_i ? mem[rd_i.addr] : noise_reg;
  // Writes land at the edge that samples the strobe
  always @(posedge sys_clk_i) begin
    noise_reg <= ~noise_reg;
    if (wr_en_i) mem[wr_i.addr] <= wr_i.data;
  end
endmodule : rrsf_mem_model
`default_nettype wire

// ---- rrsf_pkg.sv ----
// Types for the rotate-right and set-file execution block.
// Assumes no other package.
package rrsf_pkg;
  typedef enum logic [1:0] {RRSF_PH_Q1, RRSF_PH_Q2, RRSF_PH_Q3, RRSF_PH_Q4} rrsf_phase_e;
  typedef enum logic [1:0] {RRSF_OP_NONE, RRSF_OP_RRC, RRSF_OP_RRN, RRSF_OP_SET} rrsf_op_e;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] data;
  } rrsf_mem_s;
  typedef struct packed {
    logic carry;
    logic neg;
    logic zero;
  } rrsf_flags_s;
endpackage : rrsf_pkg
